// file: dwc_pkg.sv
package dwc_pkg;

	localparam int APB_AW = 12;
	localparam int BUS_AW = 28;

	// Register byte addresses on the APB slave
	localparam logic [11:0] WAIT_CTRL_OFFSET = 12'h000;
	localparam logic [11:0] DRAM_CFG_OFFSET = 12'h004;

	// Power-on values
	localparam logic [15:0] WAIT_CTRL_RESET = 16'hF800;
	localparam logic [15:0] DRAM_CFG_RESET = 16'h0000;

	// Writable bits; all others are reserved, read as zero
	localparam logic [15:0] WAIT_CTRL_MASK = 16'hF800;
	localparam logic [15:0] DRAM_CFG_MASK = 16'hFF00;

	// Wait/long-wait control fields
	localparam int WAIT_PIN_PULLUP_BIT = 15;
	localparam int AREA02_LONGWAIT_HI = 14;
	localparam int AREA02_LONGWAIT_LO = 13;
	localparam int AREA6_LONGWAIT_HI = 12;
	localparam int AREA6_LONGWAIT_LO = 11;

	// DRAM area configuration fields
	localparam int STROBE_SCHEME_BIT = 15;
	localparam int ROW_STROBE_HOLD_BIT = 14;
	localparam int PRECHARGE_LENGTH_BIT = 13;
	localparam int BURST_PAGE_EN_BIT = 12;
	localparam int CAS_DUTY_BIT = 11;
	localparam int ADDR_MUX_EN_BIT = 10;
	localparam int MUX_SHIFT_HI = 9;
	localparam int MUX_SHIFT_LO = 8;

	// Area numbers seen on the bus cycle
	localparam logic [2:0] AREA_0 = 3'h0;
	localparam logic [2:0] AREA_1 = 3'h1;
	localparam logic [2:0] AREA_2 = 3'h2;
	localparam logic [2:0] AREA_6 = 3'h6;

	localparam logic [1:0] PRECHARGE_SHORT = 2'h1;
	localparam logic [1:0] PRECHARGE_LONG = 2'h2;

	typedef enum logic [1:0] {
		DWC_SHIFT_8 = 2'h0,
		DWC_SHIFT_9 = 2'h1,
		DWC_SHIFT_10 = 2'h2,
		DWC_SHIFT_RSVD = 2'h3
	} dwc_shift_t;

	// Long wait code 00..11 means 1..4 states
	function automatic logic [2:0] dwcLongWait(input logic [1:0] code);
		return {1'b0, code} + 3'h1;
	endfunction

	// Row address bits that take part in the page compare
	function automatic logic [27:0] dwcRowMask(input dwc_shift_t s);
		unique case (s)
			DWC_SHIFT_9: return 28'hFFFFE00;
			DWC_SHIFT_10: return 28'hFFFFC00;
			default: return 28'hFFFFF00;
		endcase
	endfunction

	// Row address moved down onto the multiplexed pins
	function automatic logic [27:0] dwcRowShift(input dwc_shift_t s,
		input logic [27:0] a);
		unique case (s)
			DWC_SHIFT_9: return a >> 9;
			DWC_SHIFT_10: return a >> 10;
			default: return a >> 8;
		endcase
	endfunction

endpackage

// file: dwc_config_regs.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Wait control register loads F800 on power-on only; kept over manual reset, standby.
// - Bit 15 set enables the wait-pin pull-up; cleared disables it.
// - Bits 14:13 give areas 0 and 2 long waits of 1 to 4.
// - Bits 12:11 give area 6 long waits of 1 to 4.
// - Wait control bits 10:0 read zero; software writes zero.
// - DRAM config register clears on power-on only; kept over manual reset, standby.
// - DRAM config acts only while DRAM space enable is set.
// - 16-bit: scheme 0 uses upper/lower CAS, lower write; 1 uses lower CAS, both writes.
// - 8-bit accesses use only lower CAS and lower write strobes.
// - On a pause, hold bit 0 raises RAS, 1 keeps it low.
// - Precharge length bit gives one precharge state when 0, two when 1.
// - Burst off: every access is full, row address out, no compare.
// - Burst on: row match gives fast page access, column and CAS only.
// - CAS duty bit sets short-pitch CAS high time to 50 or 35 percent.
// - Mux enable bit multiplexes row and column onto address pins.
// - Shift code 00/01/10 moves row down 8/9/10 bits; 11 reserved.
// - Same code sets compared row bits from A8, A9 or A10 up to A27.
// - DRAM config bits 7:0 read zero; software writes zero.
// - Area 1 is DRAM space while DRAM space enable is set, else memory.
// - Areas 0, 2, 6 single DMA cycles take one state plus long waits.
module dwc_config_regs (
	input wire logic sys_clk, // 200 MHz clock
	input wire logic sys_rst, // Power-on reset, synchronous
	input wire logic manualRst, // Manual reset, leaves registers alone
	input wire logic standbyMode, // Standby, leaves registers alone
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [dwc_pkg::APB_AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic dramSpaceEnable, // DRAM space enable from bus control
	input wire logic busCycleStart, // Pulse: external bus cycle begins
	input wire logic [2:0] cycleArea, // Area of the starting cycle
	input wire logic [dwc_pkg::BUS_AW-1:0] cycleAddr, // Address of cycle
	input wire logic cycleIs16Bit, // Starting cycle targets 16-bit space
	input wire logic cycleIsDmaSingle, // Starting cycle is single-mode DMA
	output logic waitPinPullup, // Pull-up enable for wait input pin
	output logic area1IsDram, // Current cycle uses DRAM timing
	output logic [2:0] longWaitStates, // Long waits for current cycle
	output logic [2:0] dmaMemStates, // States of a single DMA cycle, base state plus long waits
	output logic upperColumnStrobe, // Upper CAS strobe in use
	output logic lowerColumnStrobe, // Lower CAS strobe in use
	output logic upperWriteStrobe, // Upper write strobe in use
	output logic lowerWriteStrobe, // Lower write strobe in use
	output logic rowStrobeHold, // Keep RAS low while idle
	output logic [1:0] prechargeStates, // Precharge state count
	output logic pageHit, // Fast page access, no row output
	output logic casDuty35, // CAS high 35 percent of column state
	output logic addrMuxActive, // Row/column multiplexing in use
	output logic [dwc_pkg::BUS_AW-1:0] dramAddrOut // Row address on pins
);
	import dwc_pkg::*;

	logic [15:0] waitCtrl_q;
	logic [15:0] waitCtrl_d;
	logic [15:0] dramCfg_q;
	logic [15:0] dramCfg_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	logic waitPinPullup_q;
	logic area1IsDram_q;
	logic [2:0] longWaitStates_q;
	logic [2:0] dmaMemStates_q;
	logic upperCas_q;
	logic lowerCas_q;
	logic upperWr_q;
	logic lowerWr_q;
	logic rowHold_q;
	logic [1:0] precharge_q;
	logic pageHit_q;
	logic casDuty_q;
	logic muxActive_q;
	logic [BUS_AW-1:0] dramAddr_q;
	logic [BUS_AW-1:0] lastRow_q;
	logic lastRowValid_q;

	// Bus decode
	wire selWait = paddr == WAIT_CTRL_OFFSET;
	wire selDram = paddr == DRAM_CFG_OFFSET;
	wire mapped = selWait | selDram;
	wire setupPhase = psel & ~penable;
	wire accessDone = psel & penable;
	wire wrEn = accessDone & pwrite & mapped;
	wire [15:0] laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Field decode of the stored registers
	wire [1:0] area02Code = waitCtrl_q[AREA02_LONGWAIT_HI:AREA02_LONGWAIT_LO];
	wire [1:0] area6Code = waitCtrl_q[AREA6_LONGWAIT_HI:AREA6_LONGWAIT_LO];
	wire schemeDualWe = dramCfg_q[STROBE_SCHEME_BIT];
	wire holdBit = dramCfg_q[ROW_STROBE_HOLD_BIT];
	wire longPrecharge = dramCfg_q[PRECHARGE_LENGTH_BIT];
	wire burstEn = dramCfg_q[BURST_PAGE_EN_BIT];
	wire dutyBit = dramCfg_q[CAS_DUTY_BIT];
	wire muxEn = dramCfg_q[ADDR_MUX_EN_BIT];
	wire dwc_shift_t shiftCode = dwc_shift_t'(
		dramCfg_q[MUX_SHIFT_HI:MUX_SHIFT_LO]);

	// Cycle classification at cycle start
	wire isDram = (cycleArea == AREA_1) & dramSpaceEnable;
	wire isArea02 = (cycleArea == AREA_0) | (cycleArea == AREA_2);
	wire isArea6 = cycleArea == AREA_6;
	wire [2:0] nextLongWait = isArea02 ? dwcLongWait(area02Code) :
		isArea6 ? dwcLongWait(area6Code) : 3'h0;
	// Single DMA: one base state plus long waits
	wire [2:0] nextDmaStates = 3'h1 + nextLongWait;

	// Strobe set; an 8-bit space never uses the upper strobes
	wire nextUpperCas = isDram & cycleIs16Bit & ~schemeDualWe;
	wire nextLowerCas = isDram;
	wire nextUpperWr = isDram & cycleIs16Bit & schemeDualWe;
	wire nextLowerWr = isDram;

	// Page compare uses the row field chosen by the shift code alone
	wire [BUS_AW-1:0] rowMask = dwcRowMask(shiftCode);
	wire rowMatch = (cycleAddr & rowMask) == (lastRow_q & rowMask);
	wire nextPageHit = isDram & burstEn & lastRowValid_q & rowMatch;
	wire nextMux = isDram & muxEn;
	wire [BUS_AW-1:0] nextAddr = nextMux ?
		dwcRowShift(shiftCode, cycleAddr) : cycleAddr;
	wire [1:0] nextPrecharge = ~isDram ? 2'h0 :
		longPrecharge ? PRECHARGE_LONG : PRECHARGE_SHORT;

	// Register writes; reserved bits are never stored
	always_comb begin
		waitCtrl_d = waitCtrl_q;
		dramCfg_d = dramCfg_q;
		if (wrEn && selWait) begin
			waitCtrl_d = ((pwdata[15:0] & laneMask) |
				(waitCtrl_q & ~laneMask)) & WAIT_CTRL_MASK;
		end
		if (wrEn && selDram) begin
			dramCfg_d = ((pwdata[15:0] & laneMask) |
				(dramCfg_q & ~laneMask)) & DRAM_CFG_MASK;
		end
	end

	// Read data is captured in the setup cycle so it is a flop in access
	always_comb begin
		prdata_d = prdata_q;
		if (setupPhase) begin
			prdata_d = selWait ? {16'h0000, waitCtrl_q} :
				selDram ? {16'h0000, dramCfg_q} : 32'h00000000;
		end
	end

	// Only power-on reset touches the registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			waitCtrl_q <= WAIT_CTRL_RESET;
			dramCfg_q <= DRAM_CFG_RESET;
			prdata_q <= 32'h00000000;
		end else begin
			waitCtrl_q <= waitCtrl_d;
			dramCfg_q <= dramCfg_d;
			prdata_q <= prdata_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			waitPinPullup_q <= WAIT_CTRL_RESET[WAIT_PIN_PULLUP_BIT];
		end else begin
			waitPinPullup_q <= waitCtrl_d[WAIT_PIN_PULLUP_BIT];
		end
	end

	// Cycle attributes are frozen at cycle start, so a write landing
	// mid-cycle cannot disturb strobes already on the pins.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			area1IsDram_q <= 1'b0;
			longWaitStates_q <= 3'h0;
			dmaMemStates_q <= 3'h1;
			upperCas_q <= 1'b0;
			lowerCas_q <= 1'b0;
			upperWr_q <= 1'b0;
			lowerWr_q <= 1'b0;
			precharge_q <= 2'h0;
			pageHit_q <= 1'b0;
			casDuty_q <= 1'b0;
			muxActive_q <= 1'b0;
			dramAddr_q <= '0;
		end else if (busCycleStart) begin
			area1IsDram_q <= isDram;
			longWaitStates_q <= nextLongWait;
			dmaMemStates_q <= cycleIsDmaSingle ? nextDmaStates : 3'h1;
			upperCas_q <= nextUpperCas;
			lowerCas_q <= nextLowerCas;
			upperWr_q <= nextUpperWr;
			lowerWr_q <= nextLowerWr;
			precharge_q <= nextPrecharge;
			pageHit_q <= nextPageHit;
			casDuty_q <= isDram & dutyBit;
			muxActive_q <= nextMux;
			dramAddr_q <= nextAddr;
		end
	end

	// Row hold follows each DRAM cycle; another area releases RAS
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rowHold_q <= 1'b0;
		end else if (busCycleStart) begin
			rowHold_q <= isDram & holdBit;
		end
	end

	// An open row cannot survive a manual reset or standby, so the page
	// history is dropped there while the settings themselves are kept.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || manualRst || standbyMode) begin
			lastRowValid_q <= 1'b0;
			lastRow_q <= '0;
		end else if (busCycleStart && isDram) begin
			lastRowValid_q <= 1'b1;
			lastRow_q <= cycleAddr;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = accessDone & ~mapped;
	assign waitPinPullup = waitPinPullup_q;
	assign area1IsDram = area1IsDram_q;
	assign longWaitStates = longWaitStates_q;
	assign dmaMemStates = dmaMemStates_q;
	assign upperColumnStrobe = upperCas_q;
	assign lowerColumnStrobe = lowerCas_q;
	assign upperWriteStrobe = upperWr_q;
	assign lowerWriteStrobe = lowerWr_q;
	assign rowStrobeHold = rowHold_q;
	assign prechargeStates = precharge_q;
	assign pageHit = pageHit_q;
	assign casDuty35 = casDuty_q;
	assign addrMuxActive = muxActive_q;
	assign dramAddrOut = dramAddr_q;

	a_poweron_wait: assert property (@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> waitCtrl_q == WAIT_CTRL_RESET)
		else $error("wait control not F800 after power-on");

	a_manual_keeps: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(manualRst || standbyMode) && !wrEn |=>
		waitCtrl_q == $past(waitCtrl_q) && dramCfg_q == $past(dramCfg_q))
		else $error("manual reset disturbed registers");

	a_pullup_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wrEn && selWait && pstrb[1] |=>
		waitPinPullup == $past(pwdata[15]))
		else $error("pull-up does not follow written bit");

	a_longwait_area02: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && cycleArea == AREA_0 |=>
		longWaitStates == {1'b0, $past(area02Code)} + 3'h1)
		else $error("area 0 long wait wrong");

	a_longwait_area6: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isArea6 && cycleIsDmaSingle |=>
		dmaMemStates == {1'b0, $past(area6Code)} + 3'h2)
		else $error("area 6 DMA states wrong");

	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		waitCtrl_q[10:0] == 11'h000 && dramCfg_q[7:0] == 8'h00)
		else $error("reserved bits stored");

	a_ignore_nodram: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && !dramSpaceEnable |=>
		!area1IsDram && !pageHit && !lowerColumnStrobe && !rowStrobeHold)
		else $error("DRAM settings used without DRAM space");

	a_strobe_8bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isDram && !cycleIs16Bit |=>
		!upperColumnStrobe && !upperWriteStrobe && lowerWriteStrobe)
		else $error("8-bit access used upper strobes");

	a_strobe_dualwe: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isDram && cycleIs16Bit |=>
		upperWriteStrobe == $past(schemeDualWe) &&
		upperColumnStrobe == !$past(schemeDualWe))
		else $error("16-bit strobe scheme wrong");

	a_precharge_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isDram |=>
		prechargeStates == ($past(longPrecharge) ? 2'h2 : 2'h1))
		else $error("precharge length wrong");

	a_full_access: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && !burstEn |=> !pageHit)
		else $error("page hit with burst off");

	a_page_repeat: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isDram && burstEn && !manualRst && !standbyMode
		##1 !busCycleStart && !wrEn && !manualRst && !standbyMode
		##1 busCycleStart && isDram && burstEn &&
		cycleAddr == $past(cycleAddr, 2)
		|=> pageHit)
		else $error("same row missed page hit");

	a_mux_shift9: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isDram && muxEn && shiftCode == DWC_SHIFT_9 |=>
		dramAddrOut == ($past(cycleAddr) >> 9))
		else $error("row shift by 9 wrong");

	a_cas_duty: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busCycleStart && isDram |=> casDuty35 == $past(dutyBit))
		else $error("CAS duty wrong");

	a_hold_mid_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!busCycleStart |=>
		$stable(rowStrobeHold) && $stable(prechargeStates) && $stable(pageHit))
		else $error("setting changed inside a bus cycle");

	a_poweron_dram: assert property (@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> dramCfg_q == DRAM_CFG_RESET)
		else $error("DRAM config not clear after power-on");

	a_longwait_area2: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && cycleArea == AREA_2 |=>
		longWaitStates == {1'b0, $past(area02Code)} + 3'h1)
		else $error("area 2 long wait wrong");

	a_longwait_a6: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && isArea6 |=>
		longWaitStates == {1'b0, $past(area6Code)} + 3'h1)
		else $error("area 6 long wait wrong");

	a_other_nowait: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && !isArea02 && !isArea6 |=>
		longWaitStates == 3'h0 && dmaMemStates == 3'h1)
		else $error("long wait given to another area");

	a_row_hold: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && isDram |=>
		rowStrobeHold == $past(holdBit))
		else $error("RAS hold wrong");

	a_lower_strobes: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && isDram |=>
		lowerColumnStrobe && lowerWriteStrobe)
		else $error("lower strobes missing");

	a_mux_shift8: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		busCycleStart && isDram && muxEn && shiftCode == DWC_SHIFT_8 |=>
		dramAddrOut == ($past(cycleAddr) >> 8))
		else $error("row shift by 8 wrong");

	a_mux_shift10: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		busCycleStart && isDram && muxEn && shiftCode == DWC_SHIFT_10 |=>
		dramAddrOut == ($past(cycleAddr) >> 10))
		else $error("row shift by 10 wrong");

	a_page_miss8: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && shiftCode == DWC_SHIFT_8
		&& cycleAddr[27:8] != lastRow_q[27:8] |=> !pageHit)
		else $error("page hit on a new row");

	a_dram_flag: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart |=> area1IsDram ==
		($past(cycleArea) == AREA_1 && $past(dramSpaceEnable)))
		else $error("DRAM space flag wrong");

	a_plain_cycle: assert property (@(posedge sys_clk)
		disable iff (sys_rst) busCycleStart && !isDram |=>
		prechargeStates == 2'h0 && !casDuty35 && !addrMuxActive &&
		dramAddrOut == $past(cycleAddr))
		else $error("DRAM timing used outside DRAM space");

	a_read_upper: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		psel && penable |-> prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");

endmodule

// file: dwc_bus_model.sv
`timescale 1ns/10ps
// Far-side bus sequencer: launches one external bus cycle per request
module dwc_bus_model (
	input wire logic sys_clk, // Clock
	input wire logic reqStart, // Bench asks for a cycle
	input wire logic [2:0] reqArea, // Area of the requested cycle
	input wire logic [27:0] reqAddr, // Address of the requested cycle
	input wire logic req16, // Requested cycle is 16-bit
	input wire logic reqDma, // Requested cycle is single DMA
	output logic busCycleStart, // Start pulse
	output logic [2:0] cycleArea, // Area
	output logic [27:0] cycleAddr, // Address
	output logic cycleIs16Bit, // 16-bit space
	output logic cycleIsDmaSingle // Single DMA
);
	initial begin
		busCycleStart = 1'b0;
		cycleArea = 3'h0;
		cycleAddr = 28'h0;
		cycleIs16Bit = 1'b0;
		cycleIsDmaSingle = 1'b0;
	end
	// Attributes scramble between starts so a stale capture shows up
	always @(posedge sys_clk) begin
		busCycleStart <= reqStart;
		cycleArea <= reqStart ? reqArea : ~cycleArea;
		cycleAddr <= reqStart ? reqAddr : ~cycleAddr;
		cycleIs16Bit <= reqStart ? req16 : ~cycleIs16Bit;
		cycleIsDmaSingle <= reqStart ? reqDma : ~cycleIsDmaSingle;
	end
endmodule

// file: dwc_config_regs_tb_top.sv
`timescale 1ns/10ps
module dwc_config_regs_tb_top;
	import dwc_pkg::*;
	logic sys_clk = 1'b0, sys_rst = 1'b1, manualRst = 1'b0, standbyMode = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dramSpaceEnable = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, busCycleStart, cycleIs16Bit, cycleIsDmaSingle;
	logic reqStart = 1'b0, req16 = 1'b0, reqDma = 1'b0;
	logic [2:0] reqArea = 3'h0, cycleArea, longWaitStates, dmaMemStates;
	logic [27:0] reqAddr = 28'h0, cycleAddr, dramAddrOut;
	logic waitPinPullup, area1IsDram, ucs, lcs, uws, lws, rowStrobeHold;
	logic casDuty35, addrMuxActive, pageHit;
	logic [1:0] prechargeStates;
	int mismatches = 0, checked = 0, cycles = 0;
	wire [10:0] flags = {area1IsDram, ucs, lcs, uws, lws, rowStrobeHold,
		prechargeStates, casDuty35, addrMuxActive, pageHit};
	always #2.5 sys_clk = ~sys_clk;
	dwc_bus_model bus_u (.sys_clk(sys_clk), .reqStart(reqStart),
		.reqArea(reqArea), .reqAddr(reqAddr), .req16(req16), .reqDma(reqDma),
		.busCycleStart(busCycleStart), .cycleArea(cycleArea),
		.cycleAddr(cycleAddr), .cycleIs16Bit(cycleIs16Bit),
		.cycleIsDmaSingle(cycleIsDmaSingle));
	dwc_config_regs dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.manualRst(manualRst), .standbyMode(standbyMode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dramSpaceEnable(dramSpaceEnable), .busCycleStart(busCycleStart),
		.cycleArea(cycleArea), .cycleAddr(cycleAddr),
		.cycleIs16Bit(cycleIs16Bit), .cycleIsDmaSingle(cycleIsDmaSingle),
		.waitPinPullup(waitPinPullup), .area1IsDram(area1IsDram),
		.longWaitStates(longWaitStates), .dmaMemStates(dmaMemStates),
		.upperColumnStrobe(ucs), .lowerColumnStrobe(lcs),
		.upperWriteStrobe(uws), .lowerWriteStrobe(lws),
		.rowStrobeHold(rowStrobeHold), .prechargeStates(prechargeStates),
		.pageHit(pageHit), .casDuty35(casDuty35),
		.addrMuxActive(addrMuxActive), .dramAddrOut(dramAddrOut));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Setup, then access until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic cyc(input logic [2:0] ar, input logic [27:0] ad,
		input logic b16, input logic dma);
		@(posedge sys_clk);
		reqStart <= 1'b1;
		reqArea <= ar;
		reqAddr <= ad;
		req16 <= b16;
		reqDma <= dma;
		@(posedge sys_clk);
		reqStart <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic pulse_resets();
		@(posedge sys_clk);
		manualRst <= 1'b1;
		@(posedge sys_clk);
		manualRst <= 1'b0;
		standbyMode <= 1'b1;
		@(posedge sys_clk);
		standbyMode <= 1'b0;
	endtask
	task automatic t_reset();
		rdchk(WAIT_CTRL_OFFSET, 32'h0000F800);
		rdchk(DRAM_CFG_OFFSET, 32'h00000000);
		chk(32'(waitPinPullup), 32'h1);
	endtask
	// Reserved ones written on purpose: they must read back as zero
	task automatic t_wait();
		logic [31:0] v;
		for (int c = 0; c < 4; c++) begin
			v = (32'(c) << 13) | (32'(3 - c) << 11);
			apb(1'b1, WAIT_CTRL_OFFSET, v | 32'h000007FF);
			rdchk(WAIT_CTRL_OFFSET, v);
			chk(32'(waitPinPullup), 32'h0);
			cyc(AREA_0, 28'h0, 1'b1, 1'b0);
			chk(32'(longWaitStates), 32'(c + 1));
			cyc(AREA_2, 28'h0, 1'b1, 1'b1);
			chk(32'(dmaMemStates), 32'(c + 2));
			cyc(AREA_6, 28'h0, 1'b1, 1'b1);
			chk(32'(longWaitStates), 32'(4 - c));
			chk(32'(dmaMemStates), 32'(5 - c));
		end
		cyc(3'h3, 28'h0, 1'b1, 1'b1);
		chk(32'(dmaMemStates), 32'h1);
	endtask
	task automatic t_keep();
		apb(1'b1, WAIT_CTRL_OFFSET, 32'h00005000);
		apb(1'b1, DRAM_CFG_OFFSET, 32'h0000FFFF);
		rdchk(DRAM_CFG_OFFSET, 32'h0000FF00);
		pulse_resets();
		rdchk(WAIT_CTRL_OFFSET, 32'h00005000);
		rdchk(DRAM_CFG_OFFSET, 32'h0000FF00);
		cyc(AREA_1, 28'h1234567, 1'b1, 1'b0);
		chk(32'(flags), 32'h0);
		chk(32'(dramAddrOut), 32'h1234567);
	endtask
	task automatic t_strobes();
		logic [3:0] e;
		@(posedge sys_clk);
		dramSpaceEnable <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, DRAM_CFG_OFFSET, 32'(i & 1) << 15);
			cyc(AREA_1, 28'h0, i[1], 1'b0);
			e = i[1] ? (i[0] ? 4'h7 : 4'hD) : 4'h5;
			chk(32'(flags[9:6]), 32'(e));
			chk(32'(area1IsDram), 32'h1);
		end
	endtask
	task automatic t_timing();
		logic [27:0] a;
		a = 28'hABCDEF1;
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, DRAM_CFG_OFFSET, 32'h00006C00 | (32'(c) << 8));
			cyc(AREA_1, a, 1'b1, 1'b0);
			chk(32'(flags[5:1]), 32'h1B);
			chk(32'(dramAddrOut), 32'(a >> (8 + c)));
			apb(1'b1, DRAM_CFG_OFFSET, 32'(c) << 8);
			cyc(AREA_1, a, 1'b1, 1'b0);
			chk(32'(flags[5:1]), 32'h04);
			chk(32'(dramAddrOut), 32'(a));
		end
	endtask
	task automatic t_burst();
		logic [27:0] b;
		b = 28'h5A5A5A5;
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, DRAM_CFG_OFFSET, 32'h00001000 | (32'(c) << 8));
			pulse_resets();
			cyc(AREA_1, b, 1'b1, 1'b0);
			chk(32'(pageHit), 32'h0);
			cyc(AREA_1, b ^ (28'h1 << (7 + c)), 1'b1, 1'b0);
			chk(32'(pageHit), 32'h1);
			cyc(AREA_1, b ^ (28'h1 << (8 + c)), 1'b1, 1'b0);
			chk(32'(pageHit), 32'h0);
			apb(1'b1, DRAM_CFG_OFFSET, 32'(c) << 8);
			cyc(AREA_1, b ^ (28'h1 << (8 + c)), 1'b1, 1'b0);
			chk(32'(pageHit), 32'h0);
		end
	endtask
	// Outputs of a running cycle must not follow a later write
	task automatic t_apply();
		apb(1'b1, WAIT_CTRL_OFFSET, 32'h00000000);
		cyc(AREA_0, 28'h0, 1'b1, 1'b0);
		apb(1'b1, WAIT_CTRL_OFFSET, 32'h00006000);
		chk(32'(longWaitStates), 32'h1);
		cyc(AREA_0, 28'h0, 1'b1, 1'b0);
		chk(32'(longWaitStates), 32'h4);
	endtask
	task automatic t_unmapped();
		apb(1'b1, 12'h008, 32'hFFFFFFFF);
		chk(32'(err), 32'h1);
		rdchk(12'h008, 32'h0);
		chk(32'(err), 32'h1);
		rdchk(WAIT_CTRL_OFFSET, 32'h00006000);
		chk(32'(err), 32'h0);
		chk(32'(pready), 32'h1);
	endtask
	// Starts two cycles apart: the second must hit the open row
	task automatic t_close();
		apb(1'b1, DRAM_CFG_OFFSET, 32'h00001000);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			reqStart <= 1'b1;
			reqArea <= AREA_1;
			reqAddr <= 28'h0123456;
			@(posedge sys_clk);
			reqStart <= 1'b0;
		end
		@(posedge sys_clk);
		#1;
		chk(32'(pageHit), 32'h1);
	endtask
	// A later power-on reset must restore both registers
	task automatic t_poweron();
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_wait();
		t_keep();
		t_strobes();
		t_timing();
		t_burst();
		t_close();
		t_apply();
		t_unmapped();
		t_poweron();
		finish_test();
	end
endmodule
